/* File: rtl/audio_host_port_interface.sv */
// Host I/O port set of the audio controller: power, command/data, status, FIFO PIO, reset.
// Assumes ISA strobes already decoded to one-cycle rd/wr pulses synchronous to mclk.
`timescale 1ns/10ps
`include "audio_port_cfg.svh"
module audio_host_port_interface
  import audio_port_pkg::*;
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH,
  parameter int FW_DEPTH = `CTL_FW_DEPTH
)
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire io_req_t host_req,
  output logic [7:0] host_rdata,
  output logic suspend_req,
  output logic powerdown_req,
  output logic fm_reset,
  output logic analog_stays_on,
  output logic general_output_one,
  output logic general_output_zero,
  output logic ctl_reset,
  output logic [7:0] ctl_cmd_data,
  output logic ctl_cmd_valid,
  input wire logic ctl_cmd_take,
  input wire logic ctl_rd_put,
  input wire logic [7:0] ctl_rd_data,
  input wire logic ctl_irq,
  input wire logic ext_mode_set,
  input wire logic ext_mode_clr,
  input wire logic dma_start,
  input wire logic dma_overflow,
  input wire logic dma_pop,
  output logic [7:0] dma_data,
  input wire logic dma_push,
  input wire logic [7:0] dma_push_data,
  output logic irq,
  output logic mixer_defaults,
  output core_cfg_t core_cfg
);
  logic wr_pwr;
  logic wr_rst;
  logic wr_cmd;
  logic rd_data;
  logic rd_state;
  logic wr_fifo;
  logic rd_fifo;
  logic [7:0] pwr_rdata;
  logic [1:0] rst_bits_r;
  srst_state_t srst_state_r;
  logic core_reset;
  logic [7:0] rd_buf_r;
  logic avail_r;
  logic busy_r;
  logic [7:0] cmd_r;
  logic irq_ctl_r;
  logic irq_half_r;
  logic irq_dma_r;
  logic fifo_full;
  logic fifo_empty;
  logic fifo_half;
  logic half_prev_r;
  logic [7:0] fifo_out;
  logic ext_r;
  logic [7:0] status;
  core_cfg_t cfg_r;

  // Port strobe decode
  function automatic logic hit(input io_req_t r, input logic is_wr, input logic [3:0] ofs);
    hit = (is_wr ? r.wr : r.rd) && (r.addr == ofs);
  endfunction : hit

  assign wr_pwr = hit(host_req, 1'b1, `OFS_POWER_CTRL);
  assign wr_rst = hit(host_req, 1'b1, `OFS_RESET_CTRL);
  assign wr_cmd = hit(host_req, 1'b1, `OFS_WR_STATUS);
  assign rd_data = hit(host_req, 1'b0, `OFS_RD_DATA);
  assign rd_state = hit(host_req, 1'b0, `OFS_RD_STATE);
  assign wr_fifo = hit(host_req, 1'b1, `OFS_FIFO_PIO);
  assign rd_fifo = hit(host_req, 1'b0, `OFS_FIFO_PIO);

  // No wake path from power port
  audio_port_power u_power (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .wr(wr_pwr),
    .wdata(host_req.wdata),
    .rdata(pwr_rdata),
    .suspend_req(suspend_req),
    .powerdown_req(powerdown_req),
    .fm_reset(fm_reset),
    .analog_stays_on(analog_stays_on),
    .general_output_one(general_output_one),
    .general_output_zero(general_output_zero)
  );

  // Reset port bits
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rst_bits_r <= 2'b00;
    end
    else if (ce && wr_rst)
    begin
      rst_bits_r <= host_req.wdata[1:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      srst_state_r <= SRST_IDLE;
    end
    else if (ce)
    begin
      case (srst_state_r)
        SRST_IDLE:
        begin
          if (rst_bits_r[`RST_SOFT_BIT])
          begin
            srst_state_r <= SRST_HOLD;
          end
        end
        SRST_HOLD:
        begin
          if (!rst_bits_r[`RST_SOFT_BIT])
          begin
            srst_state_r <= SRST_ACK;
          end
        end
        SRST_ACK:
        begin
          srst_state_r <= SRST_IDLE;
        end
        default:
        begin
          srst_state_r <= SRST_IDLE;
        end
      endcase
    end
  end

  assign core_reset = srst || (srst_state_r == SRST_HOLD);
  assign ctl_reset = core_reset;
  assign mixer_defaults = srst;

  always_ff @(posedge mclk)
  begin
    if (core_reset)
    begin
      busy_r <= 1'b0;
      cmd_r <= 8'h00;
    end
    else if (ce)
    begin
      if (wr_cmd)
      begin
        busy_r <= 1'b1;
        cmd_r <= host_req.wdata;
      end
      else if (ctl_cmd_take)
      begin
        busy_r <= 1'b0;
      end
    end
  end
  assign ctl_cmd_valid = busy_r;
  assign ctl_cmd_data = cmd_r;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      avail_r <= 1'b0;
      rd_buf_r <= 8'h00;
    end
    else if (ce)
    begin
      if (srst_state_r == SRST_ACK)
      begin
        avail_r <= 1'b1;
        rd_buf_r <= `ACK_BYTE;
      end
      else if (srst_state_r == SRST_HOLD)
      begin
        avail_r <= 1'b0;
      end
      else if (ctl_rd_put)
      begin
        avail_r <= 1'b1;
        rd_buf_r <= ctl_rd_data;
      end
      else if (rd_data)
      begin
        avail_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (core_reset)
    begin
      ext_r <= 1'b0;
    end
    else if (ce)
    begin
      if (ext_mode_set)
      begin
        ext_r <= 1'b1;
      end
      else if (ext_mode_clr)
      begin
        ext_r <= 1'b0;
      end
    end
  end

  audio_port_fifo #(
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .srst(core_reset),
    .ce(ce),
    .flush(rst_bits_r[`RST_FIFO_BIT] && ext_r),
    .push((wr_fifo || dma_push) && ext_r),
    .push_data(wr_fifo ? host_req.wdata : dma_push_data),
    .pop((rd_fifo || dma_pop) && ext_r),
    .pop_data(fifo_out),
    .full(fifo_full),
    .empty(fifo_empty),
    .half_empty(fifo_half)
  );
  assign dma_data = fifo_out;

  always_ff @(posedge mclk)
  begin
    if (core_reset)
    begin
      irq_ctl_r <= 1'b0;
      irq_half_r <= 1'b0;
      irq_dma_r <= 1'b0;
      half_prev_r <= 1'b1;
    end
    else if (ce)
    begin
      half_prev_r <= fifo_half;
      irq_ctl_r <= ctl_irq || (irq_ctl_r && !rd_state);
      irq_half_r <= (ext_r && (fifo_half != half_prev_r)) || (irq_half_r && !rd_state);
      irq_dma_r <= (ext_r && dma_overflow) || (irq_dma_r && !rd_state);
    end
  end
  assign irq = irq_ctl_r || irq_half_r || irq_dma_r;

  assign status = {busy_r, avail_r, ext_r && fifo_full, ext_r && fifo_empty,
                   ext_r && fifo_half, irq_ctl_r, irq_half_r, irq_dma_r};

  always_ff @(posedge mclk)
  begin
    if (core_reset)
    begin
      cfg_r.ext_mode <= 1'b0;
      cfg_r.timebase_khz <= 11'(`TB_LEGACY_KHZ);
      cfg_r.dma_run <= 1'b0;
      cfg_r.dac_to_mixer <= 1'b0;
      cfg_r.timer_div <= `TIMER_DIV_RESET;
      cfg_r.filter_div <= `FILTER_DIV_RESET;
      cfg_r.compat_count <= `DMA_COUNT_RESET;
      cfg_r.ext_count <= `DMA_COUNT_RESET;
      cfg_r.codec_is_dac <= 1'b1;
      cfg_r.codec_level <= `CODEC_MID_LEVEL;
      cfg_r.rec_vol8 <= `REC_VOL8_MAX;
      cfg_r.rec_vol16 <= `REC_VOL16_MID;
    end
    else if (ce)
    begin
      if (dma_start)
      begin
        cfg_r.dma_run <= 1'b1;
      end
    end
  end

  always_comb
  begin
    core_cfg = cfg_r;
    core_cfg.ext_mode = ext_r;
    core_cfg.timebase_khz = ext_r ? 11'(`TB_EXT_KHZ) : 11'(`TB_LEGACY_KHZ);
  end

  // Read data mux
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      host_rdata <= 8'h00;
    end
    else if (ce && host_req.rd)
    begin
      if (host_req.addr == `OFS_POWER_CTRL)
      begin
        host_rdata <= pwr_rdata;
      end
      else if (host_req.addr == `OFS_RESET_CTRL)
      begin
        host_rdata <= {6'h00, rst_bits_r};
      end
      else if (host_req.addr == `OFS_RD_DATA)
      begin
        host_rdata <= rd_buf_r;
      end
      else if (host_req.addr == `OFS_WR_STATUS)
      begin
        host_rdata <= status;
      end
      else if (host_req.addr == `OFS_RD_STATE)
      begin
        host_rdata <= {avail_r, 7'h00};
      end
      else if (host_req.addr == `OFS_FIFO_PIO)
      begin
        host_rdata <= ext_r ? fifo_out : 8'h00;
      end
      else
      begin
        host_rdata <= 8'hFF;
      end
    end
  end
endmodule : audio_host_port_interface

/* File: rtl/audio_port_cfg.svh */
// Constants for the audio host port: offsets, bit positions, reset values, timing.
// Included by the package and by every design file.
`ifndef AUDIO_PORT_CFG_SVH
`define AUDIO_PORT_CFG_SVH
`define OFS_RESET_CTRL 4'h6
`define OFS_POWER_CTRL 4'h7
`define OFS_RD_DATA 4'hA
`define OFS_WR_STATUS 4'hC
`define OFS_RD_STATE 4'hE
`define OFS_FIFO_PIO 4'hF
`define PWR_SUSPEND 7
`define PWR_FM_RESET 5
`define PWR_ANALOG_ON 3
`define PWR_DOWN_REQ 2
`define PWR_GENERAL_OUTPUT_ONE 1
`define PWR_GENERAL_OUTPUT_ZERO 0
`define PWR_WRITE_MASK 8'hAF
`define PWR_RESET_VAL 8'h02
`define RST_SOFT_BIT 0
`define RST_FIFO_BIT 1
`define ST_BUSY 7
`define ST_AVAIL 6
`define ST_FULL 5
`define ST_EMPTY 4
`define ST_HALF 3
`define ST_IRQ_CTL 2
`define ST_IRQ_HALF 1
`define ST_IRQ_DMA 0
`define ACK_BYTE 8'hAA
`define DMA_COUNT_RESET 16'h0800
`define TIMER_DIV_RESET 8'h83
`define FILTER_DIV_RESET 8'h83
`define CODEC_MID_LEVEL 16'h8000
`define REC_VOL8_MAX 4'hF
`define REC_VOL16_MID 4'h8
`define FIFO_DEPTH 256
`define CTL_FW_DEPTH 64
`define TB_LEGACY_KHZ 1000
`define TB_EXT_KHZ 800
`define CLK_KHZ 100000
`endif

/* File: rtl/audio_port_fifo.sv */
// Hardware-managed byte FIFO for extended mode with level flags.
// Assumes one writer and one reader on mclk; pushes to a full FIFO are dropped.
`timescale 1ns/10ps
`include "audio_port_cfg.svh"
module audio_port_fifo
  import audio_port_pkg::*;
#(
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
)
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic flush,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  output logic [7:0] pop_data,
  output logic full,
  output logic empty,
  output logic half_empty
);
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic do_push;
  logic do_pop;

  assign full = (cnt_r == (AW+1)'(DEPTH));
  assign empty = (cnt_r == '0);
  assign half_empty = (cnt_r < (AW+1)'(DEPTH / 2));
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign pop_data = mem[rp_r];

  always_ff @(posedge mclk)
  begin
    if (ce && do_push)
    begin
      mem[wp_r] <= push_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst || (ce && flush))
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else if (ce)
    begin
      if (do_push)
      begin
        wp_r <= wp_r + 1'b1;
      end
      if (do_pop)
      begin
        rp_r <= rp_r + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        cnt_r <= cnt_r + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule : audio_port_fifo

/* File: rtl/audio_port_pkg.sv */
// Types shared by the audio host port modules.
// Assumes audio_port_cfg.svh is on the include path.
`include "audio_port_cfg.svh"
package audio_port_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic ext_mode;
    logic dma_run;
    logic dac_to_mixer;
    logic codec_is_dac;
    logic [15:0] codec_level;
    logic [15:0] compat_count;
    logic [15:0] ext_count;
    logic [7:0] timer_div;
    logic [7:0] filter_div;
    logic [3:0] rec_vol8;
    logic [3:0] rec_vol16;
    logic [10:0] timebase_khz;
  } core_cfg_t;

  typedef enum logic [1:0] {
    SRST_IDLE = 2'b00,
    SRST_HOLD = 2'b01,
    SRST_ACK = 2'b10
  } srst_state_t;
endpackage : audio_port_pkg

/* File: rtl/audio_port_power.sv */
// Power management port: pulse requests, FM reset, analog flag, general outputs.
// Assumes writes arrive as one-cycle strobes from the port decoder.
`timescale 1ns/10ps
`include "audio_port_cfg.svh"
module audio_port_power
  import audio_port_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic wr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic suspend_req,
  output logic powerdown_req,
  output logic fm_reset,
  output logic analog_stays_on,
  output logic general_output_one,
  output logic general_output_zero
);
  logic [7:0] pwr_r;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pwr_r <= `PWR_RESET_VAL;
    end
    else if (ce && wr)
    begin
      pwr_r <= wdata & `PWR_WRITE_MASK;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      suspend_req <= 1'b0;
      powerdown_req <= 1'b0;
    end
    else if (ce)
    begin
      suspend_req <= wr && pwr_r[`PWR_SUSPEND] && !wdata[`PWR_SUSPEND];
      powerdown_req <= wr && pwr_r[`PWR_DOWN_REQ] && !wdata[`PWR_DOWN_REQ];
    end
  end

  assign rdata = pwr_r;
  assign fm_reset = pwr_r[`PWR_FM_RESET];
  assign analog_stays_on = pwr_r[`PWR_ANALOG_ON];
  assign general_output_one = pwr_r[`PWR_GENERAL_OUTPUT_ONE];
  assign general_output_zero = pwr_r[`PWR_GENERAL_OUTPUT_ZERO];
endmodule : audio_port_power

/* File: sim/audio_host_port_interface_assertions.sv */
// Port-level checker for the audio host port.
// Assumes a single mclk domain with synchronous srst.
`timescale 1ns/10ps
`include "audio_port_cfg.svh"
module audio_host_port_interface_chk
  import audio_port_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire io_req_t host_req,
  input wire logic [7:0] host_rdata,
  input wire logic suspend_req,
  input wire logic fm_reset,
  input wire logic general_output_one,
  input wire logic general_output_zero,
  input wire logic ctl_reset,
  input wire logic ctl_cmd_valid,
  input wire logic ctl_cmd_take,
  input wire logic ctl_irq,
  input wire logic dma_overflow,
  input wire logic irq,
  input wire core_cfg_t core_cfg
);
  logic pw_q;
  logic [7:0] pd_q;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  // Power write history
  always_ff @(posedge mclk)
  begin
    pw_q <= ce && host_req.wr && host_req.addr == `OFS_POWER_CTRL;
    pd_q <= host_req.wdata;
  end
  chk_suspend_pulse: assert property (
    suspend_req |-> pw_q && !pd_q[`PWR_SUSPEND] ##1 !suspend_req)
    else $error("suspend pulse without clearing write");
  chk_fm_level: assert property (
    pw_q |-> fm_reset == pd_q[`PWR_FM_RESET]) else $error("fm reset level wrong");
  chk_gpo_levels: assert property (
    pw_q |-> {general_output_one, general_output_zero} == pd_q[1:0])
    else $error("general outputs wrong");
  chk_busy_set: assert property (
    ce && host_req.wr && host_req.addr == `OFS_WR_STATUS && !ctl_reset |=> ctl_cmd_valid)
    else $error("busy not set by command write");
  chk_busy_clear: assert property (
    ce && ctl_cmd_take && !host_req.wr |=> !ctl_cmd_valid) else $error("busy not cleared");
  chk_irq_read_clear: assert property (
    ce && host_req.rd && host_req.addr == `OFS_RD_STATE && !ctl_irq && !dma_overflow
    |=> !irq) else $error("irq not cleared by state read");
  chk_ctl_irq_seen: assert property (
    ce && ctl_irq && !ctl_reset |=> irq) else $error("controller request lost");
  chk_legacy_fifo: assert property (
    ce && host_req.rd && host_req.addr == `OFS_FIFO_PIO && !core_cfg.ext_mode
    |=> host_rdata == 8'h00) else $error("fifo port read in legacy mode");
  chk_reset_values: assert property (@(posedge mclk) disable iff (1'b0)
    srst && ce |=> general_output_one && !general_output_zero && !core_cfg.ext_mode
    && core_cfg.compat_count == `DMA_COUNT_RESET) else $error("reset state wrong");
  cover property (suspend_req);
  cover property (ctl_cmd_valid ##1 ctl_cmd_take);
  cover property (irq ##1 !irq);
endmodule : audio_host_port_interface_chk
bind audio_host_port_interface audio_host_port_interface_chk i_chk (
  .mclk(mclk),
  .srst(srst),
  .ce(ce),
  .host_req(host_req),
  .host_rdata(host_rdata),
  .suspend_req(suspend_req),
  .fm_reset(fm_reset),
  .general_output_one(general_output_one),
  .general_output_zero(general_output_zero),
  .ctl_reset(ctl_reset),
  .ctl_cmd_valid(ctl_cmd_valid),
  .ctl_cmd_take(ctl_cmd_take),
  .ctl_irq(ctl_irq),
  .dma_overflow(dma_overflow),
  .irq(irq),
  .core_cfg(core_cfg)
);

/* File: sim/ctl_model.sv */
// Embedded controller stand-in: takes command bytes and answers each one.
// Assumes the port's busy level and one-cycle take/put pulses on mclk.
`timescale 1ns/10ps
module ctl_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ctl_reset,
  input wire logic ctl_cmd_valid,
  input wire logic [7:0] ctl_cmd_data,
  input wire logic [3:0] lag,
  output logic ctl_cmd_take,
  output logic ctl_rd_put,
  output logic [7:0] ctl_rd_data,
  output logic ctl_irq
);
  logic [3:0] wait_r;
  always_ff @(posedge mclk)
  begin
    ctl_cmd_take <= 1'b0;
    ctl_rd_put <= 1'b0;
    ctl_irq <= 1'b0;
    ctl_rd_data <= ~ctl_rd_data;
    wait_r <= 4'h0;
    if (srst)
      ctl_rd_data <= 8'h5A;
    else if (!ctl_reset && ctl_cmd_valid && !ctl_cmd_take)
    begin
      wait_r <= wait_r + 4'h1;
      if (wait_r >= lag)
      begin
        ctl_cmd_take <= 1'b1;
        ctl_rd_put <= 1'b1;
        ctl_irq <= 1'b1;
        ctl_rd_data <= ~ctl_cmd_data;
      end
    end
  end
endmodule : ctl_model

/* File: sim/testbench.sv */
// Self-checking bench for the audio host port.
// Assumes the controller stand-in and a 16-byte FIFO.
`timescale 1ns/10ps
`include "audio_port_cfg.svh"
module testbench
  import audio_port_pkg::*;
;
  localparam int DEPTH = 16;
  logic mclk, srst, ce, suspend_req, powerdown_req, fm_reset, analog_stays_on;
  logic general_output_one, general_output_zero, ctl_reset, ctl_cmd_valid;
  logic ctl_cmd_take, ctl_rd_put, ctl_irq, irq, mixer_defaults, ext_mode_set;
  logic ext_mode_clr, dma_start, dma_overflow, dma_pop, dma_push;
  logic [7:0] host_rdata, ctl_cmd_data, ctl_rd_data, dma_data, dma_push_data;
  logic [7:0] pwr, d, e, q[$];
  logic [3:0] lag;
  logic [31:0] seed;
  io_req_t host_req;
  core_cfg_t core_cfg;
  int bad_count, compares;
  audio_host_port_interface #(.FIFO_DEPTH(DEPTH)) i_dut (
    .mclk(mclk), .srst(srst), .ce(ce), .host_req(host_req), .host_rdata(host_rdata),
    .suspend_req(suspend_req), .powerdown_req(powerdown_req), .fm_reset(fm_reset),
    .analog_stays_on(analog_stays_on), .general_output_one(general_output_one),
    .general_output_zero(general_output_zero), .ctl_reset(ctl_reset),
    .ctl_cmd_data(ctl_cmd_data), .ctl_cmd_valid(ctl_cmd_valid),
    .ctl_cmd_take(ctl_cmd_take), .ctl_rd_put(ctl_rd_put), .ctl_rd_data(ctl_rd_data),
    .ctl_irq(ctl_irq), .ext_mode_set(ext_mode_set), .ext_mode_clr(ext_mode_clr),
    .dma_start(dma_start), .dma_overflow(dma_overflow), .dma_pop(dma_pop),
    .dma_data(dma_data), .dma_push(dma_push), .dma_push_data(dma_push_data), .irq(irq),
    .mixer_defaults(mixer_defaults), .core_cfg(core_cfg));
  ctl_model i_ctl (.mclk(mclk), .srst(srst), .ctl_reset(ctl_reset),
    .ctl_cmd_valid(ctl_cmd_valid), .ctl_cmd_data(ctl_cmd_data), .lag(lag),
    .ctl_cmd_take(ctl_cmd_take), .ctl_rd_put(ctl_rd_put), .ctl_rd_data(ctl_rd_data),
    .ctl_irq(ctl_irq));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic core_cfg_t cfg_exp();
    core_cfg_t c;
    c = '0;
    c.codec_is_dac = 1'b1;
    c.codec_level = `CODEC_MID_LEVEL;
    c.compat_count = `DMA_COUNT_RESET;
    c.ext_count = `DMA_COUNT_RESET;
    c.timer_div = `TIMER_DIV_RESET;
    c.filter_div = `FILTER_DIV_RESET;
    c.rec_vol8 = `REC_VOL8_MAX;
    c.rec_vol16 = `REC_VOL16_MID;
    c.timebase_khz = 11'h3E8;
    return c;
  endfunction : cfg_exp
  task automatic finish_test();
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic io(input logic w, input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    #1 host_req = '{rd: !w, wr: w, addr: a, wdata: v};
    @(posedge mclk);
    #1 host_req = '0;
  endtask : io
  task automatic poll(input logic [3:0] a, input int b);
    int n;
    n = 0;
    do
    begin
      io(1'b0, a, 8'h00);
      n++;
    end
    while (host_rdata[b] !== 1'b1 && n < 60);
    if (host_rdata[b] !== 1'b1)
    begin
      check("poll", 1'b0, 1'b1);
      finish_test();
    end
  endtask : poll
  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    host_req = '0;
    {ext_mode_set, ext_mode_clr, dma_start, dma_overflow, dma_pop, dma_push} = '0;
    dma_push_data = 8'h00;
    lag = 4'h0;
    seed = 32'h8E4E;
    bad_count = 0;
    compares = 0;
    repeat (2) @(posedge mclk);
    #1 check("mixer_defaults", mixer_defaults, 1'b1);
    srst = 1'b0;
    io(1'b0, `OFS_POWER_CTRL, 8'h00);
    check("power_reset", host_rdata, `PWR_RESET_VAL);
    check("cfg_reset", core_cfg, cfg_exp());
    io(1'b0, `OFS_WR_STATUS, 8'h00);
    check("status_reset", host_rdata, 8'h00);
    pwr = `PWR_RESET_VAL;
    for (int i = 0; i < 12; i++)
    begin
      seed = lfsr(seed);
      d = i == 0 ? 8'h84 : i == 1 ? 8'h00 : seed[7:0];
      io(1'b1, `OFS_POWER_CTRL, d);
      check("suspend", suspend_req, pwr[7] & ~d[7]);
      check("powerdown", powerdown_req, pwr[2] & ~d[2]);
      check("levels", {fm_reset, analog_stays_on, general_output_one, general_output_zero},
        {d[5], d[3], d[1:0]});
      pwr = d & `PWR_WRITE_MASK;
      io(1'b0, `OFS_POWER_CTRL, 8'h00);
      check("power_read", host_rdata, pwr);
    end
    for (int i = 0; i < 5; i++)
    begin
      seed = lfsr(seed);
      lag = i == 0 ? 4'h0 : seed[3:0];
      d = seed[15:8];
      e = ~d;
      io(1'b1, `OFS_WR_STATUS, d);
      check("cmd_data", {ctl_cmd_valid, ctl_cmd_data}, {1'b1, d});
      poll(`OFS_WR_STATUS, `ST_AVAIL);
      check("status_cmd", {irq, host_rdata}, {1'b1, 8'h44});
      io(1'b0, `OFS_RD_STATE, 8'h00);
      check("state_avail", {irq, host_rdata[7]}, 2'b01);
      io(1'b0, `OFS_RD_DATA, 8'h00);
      check("read_data", host_rdata, e);
      io(1'b0, `OFS_RD_STATE, 8'h00);
      check("avail_clear", host_rdata[7], 1'b0);
    end
    lag = 4'h9;
    @(posedge mclk);
    #1 host_req = '{rd: 1'b0, wr: 1'b1, addr: `OFS_WR_STATUS, wdata: 8'h3C};
    @(posedge mclk);
    #1 host_req = '{rd: 1'b1, wr: 1'b0, addr: `OFS_WR_STATUS, wdata: 8'h00};
    @(posedge mclk);
    #1 host_req = '0;
    check("b2b_busy", host_rdata[7], 1'b1);
    poll(`OFS_RD_STATE, 7);
    io(1'b0, `OFS_RD_DATA, 8'h00);
    check("b2b_data", host_rdata, 8'hC3);
    ext_mode_set = 1'b1;
    dma_start = 1'b1;
    @(posedge mclk);
    #1 {ext_mode_set, dma_start} = 2'b00;
    check("ext", {core_cfg.ext_mode, core_cfg.dma_run, core_cfg.timebase_khz},
      {2'b11, 11'h320});
    io(1'b0, `OFS_WR_STATUS, 8'h00);
    check("ext_empty", host_rdata, 8'h18);
    for (int i = 0; i <= DEPTH; i++)
    begin
      seed = lfsr(seed);
      q.push_back(seed[7:0]);
      io(1'b1, `OFS_FIFO_PIO, seed[7:0]);
    end
    void'(q.pop_back());
    io(1'b0, `OFS_WR_STATUS, 8'h00);
    check("ext_full", host_rdata, 8'h22);
    io(1'b0, `OFS_RD_STATE, 8'h00);
    dma_overflow = 1'b1;
    @(posedge mclk);
    #1 dma_overflow = 1'b0;
    io(1'b0, `OFS_WR_STATUS, 8'h00);
    check("overflow", host_rdata, 8'h21);
    check("dma_head", dma_data, q[0]);
    for (int i = 0; i < DEPTH; i++)
    begin
      io(1'b0, `OFS_FIFO_PIO, 8'h00);
      check("pio_byte", host_rdata, q.pop_front());
    end
    io(1'b0, `OFS_WR_STATUS, 8'h00);
    check("drained", host_rdata, 8'h1B);
    seed = lfsr(seed);
    dma_push_data = seed[7:0];
    dma_push = 1'b1;
    @(posedge mclk);
    #1 dma_push = 1'b0;
    check("dma_push", dma_data, seed[7:0]);
    dma_pop = 1'b1;
    @(posedge mclk);
    #1 dma_pop = 1'b0;
    io(1'b0, `OFS_WR_STATUS, 8'h00);
    check("dma_pop", host_rdata, 8'h1B);
    io(1'b1, `OFS_RESET_CTRL, 8'h01);
    repeat (2) @(posedge mclk);
    #1 check("soft_hold", {ctl_reset, mixer_defaults, irq}, 3'b100);
    check("cfg_soft", core_cfg, cfg_exp());
    io(1'b0, `OFS_POWER_CTRL, 8'h00);
    check("power_keep", host_rdata, pwr);
    io(1'b1, `OFS_RESET_CTRL, 8'h00);
    poll(`OFS_RD_STATE, 7);
    io(1'b0, `OFS_RD_DATA, 8'h00);
    check("ack_byte", host_rdata, `ACK_BYTE);
    io(1'b0, `OFS_FIFO_PIO, 8'h00);
    check("fifo_legacy", host_rdata, 8'h00);
    ext_mode_set = 1'b1;
    @(posedge mclk);
    #1 ext_mode_set = 1'b0;
    check("ext_set", core_cfg.ext_mode, 1'b1);
    ext_mode_clr = 1'b1;
    @(posedge mclk);
    #1 ext_mode_clr = 1'b0;
    check("ext_clr", {core_cfg.ext_mode, core_cfg.timebase_khz},
      {1'b0, 11'(`TB_LEGACY_KHZ)});
    finish_test();
  end
endmodule : testbench
